// *** dram_access_map.sv ***
// Shared constants, types and the external-data address decoder
package dram_access_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PHYS_W = 14;
    localparam int XADDR_W = 16;
    localparam int ROW_W = 5;
    localparam int COL_W = 6;
    localparam int BLK_W = 4;
    localparam int OFFS_W = 10;
    localparam int SEL_W = 3;
    localparam int REF_CNT_W = 12;
    // ------------------------------------------------------------
    // External data space windows
    // ------------------------------------------------------------
    localparam logic [15:0] AUX_LO = 16'h0000;
    localparam logic [15:0] AUX_HI = 16'h07ff;
    localparam logic [15:0] TTX_LO = 16'h2000;
    localparam logic [15:0] TTX_HI = 16'h47ff;
    localparam logic [15:0] CAP_LO = 16'h8000;
    localparam logic [15:0] CAP_HI = 16'h84ff;
    localparam logic [15:0] CAP_DISP_HI = 16'h845f;
    // ------------------------------------------------------------
    // Physical DRAM layout
    // ------------------------------------------------------------
    localparam logic [13:0] DISP_PHYS_BASE = 14'h0800;
    localparam logic [13:0] DISP_PHYS_LAST = 14'h2fff;
    localparam logic [7:0] SPACE_CODE = 8'h20;
    // ------------------------------------------------------------
    // Row and column pointer limits
    // ------------------------------------------------------------
    localparam logic [5:0] COL_LAST = 6'h27;
    localparam logic [5:0] COL_SPLIT = 6'h20;
    localparam logic [4:0] ROW_END = 5'h19;
    localparam logic [5:0] COL_END = 6'h17;
    localparam logic [9:0] HI_GROUP_BASE = 10'h3f8;
    // ------------------------------------------------------------
    // Register port selects
    // ------------------------------------------------------------
    localparam logic [2:0] SEL_ROW = 3'h0;
    localparam logic [2:0] SEL_COL = 3'h1;
    localparam logic [2:0] SEL_DATA = 3'h2;
    localparam logic [2:0] SEL_BLOCK = 3'h3;
    localparam logic [2:0] SEL_STATUS = 3'h4;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int REFRESH_INTERVAL_NS = 15600;
    localparam int REFRESH_CYCLES = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic {
        ST_CLEAR = 1'b0,
        ST_RUN = 1'b1
    } phase_t;
    typedef enum logic [2:0] {
        OWN_NONE = 3'b000,
        OWN_CAP = 3'b001,
        OWN_DISP = 3'b011,
        OWN_XDM = 3'b010,
        OWN_SFR = 3'b110
    } owner_t;
    // ------------------------------------------------------------
    // Row/column to block offset
    // ------------------------------------------------------------
    function automatic logic [9:0] rc_offset(input logic [4:0] row, input logic [5:0] col);
        if (col < COL_SPLIT) begin
            rc_offset = {row, col[4:0]};
        end else begin
            rc_offset = 10'(HI_GROUP_BASE - {2'h0, row, 3'h0} + {7'h00, col[2:0]});
        end
    endfunction
    // ------------------------------------------------------------
    // Pointer auto-increment
    // ------------------------------------------------------------
    function automatic logic [10:0] next_pos(input logic [4:0] row, input logic [5:0] col);
        if (row == ROW_END && col == COL_END) begin
            next_pos = '0;
        end else if (col == COL_LAST) begin
            next_pos = {5'(row + 5'h01), 6'h00};
        end else begin
            next_pos = {row, 6'(col + 6'h01)};
        end
    endfunction
endpackage

`timescale 1ns/100ps
module xdm_map (
    // External data address
    input wire logic [15:0] addr,
    // Decode result
    output logic hit,
    output logic [13:0] phys
);
    always_comb begin
        hit = 1'b0;
        phys = '0;
        if (addr <= dram_access_pkg::AUX_HI) begin
            hit = 1'b1; // [RULE_07]
            phys = addr[13:0];
        end else if (addr >= dram_access_pkg::TTX_LO && addr <= dram_access_pkg::TTX_HI) begin
            hit = 1'b1; // [RULE_08] [RULE_11]
            phys = 14'(dram_access_pkg::DISP_PHYS_BASE + 14'(addr - dram_access_pkg::TTX_LO));
        end else if (addr >= dram_access_pkg::CAP_LO && addr <= dram_access_pkg::CAP_HI) begin
            hit = 1'b1; // [RULE_08] [RULE_09]
            phys = 14'(dram_access_pkg::DISP_PHYS_BASE + 14'(addr - dram_access_pkg::CAP_LO));
        end
    end
endmodule

// *** dram_array_model.sv ***
// Behavioural model of the embedded DRAM array behind the access block
`timescale 1ns/100ps
module dram_array_model (
    // Clock
    input wire logic clk,
    // Array port
    input wire logic dram_req,
    input wire logic dram_we,
    input wire logic dram_refresh,
    input wire logic [13:0] dram_addr,
    input wire logic [7:0] dram_wdata,
    output logic [7:0] dram_rdata
);
    logic [7:0] cells [0:16383];
    initial begin
        for (int i = 0; i < 16384; i++) begin
            cells[i] = 8'(i * 37 + 11);
        end
    end
    // Cells survive reset; read data lasts one cycle, then toggles
    always @(posedge clk) begin
        if (dram_req && dram_we) begin
            cells[dram_addr] <= dram_wdata;
        end
        if (dram_req && !dram_we) begin
            dram_rdata <= cells[dram_addr];
        end else begin
            dram_rdata <= ~dram_rdata;
        end
    end
endmodule

// *** shared_display_memory_access.sv ***
// Embedded DRAM arbiter, refresh, page clear and display register port
// Contract
// RULE_01: Arbitrate DRAM among clients and perform refresh and page clearing.
// RULE_02: Capture, display and microcontroller each get access to the one DRAM.
// RULE_03: Auxiliary area gets no initial value; software initialises it.
// RULE_04: Auxiliary contents kept in idle; power-down may lose them.
// RULE_05: Display area filled with 20H at power-up; kept in idle.
// RULE_06: Idle exit by interrupt keeps display; exit by reset refills 20H.
// RULE_07: Auxiliary area is 2 kbytes at 0000H to 07FFH.
// RULE_08: Display at 2000H-47FFH or 8000H-84FFH, both same physical area.
// RULE_09: Caption display uses to 845FH; rest up to 84FFH is software space.
// RULE_10: Auxiliary and caption range only via external data moves.
// RULE_11: Teletext range reachable by external data moves and register port.
// RULE_12: Teletext block is 40 columns by 25 rows in 1K bytes.
// RULE_13: Block, row, column fields pick position; data register accesses it.
// RULE_14: Every data register access advances the row/column pointer.
// RULE_15: Column counts to 39 then wraps and row increments.
// RULE_16: Access at row 25 column 23 resets row and column to zero.
// RULE_17: Software writes only in-range pointer values.
// RULE_18: Ten-bit row/column offset added to block base gives full address.
// RULE_19: Columns 0-31 at row*20H+col; 32-39 at 3F8H minus 8*row.
// RULE_20: Reset clears whole page memory; clearing flag set until done.
// RULE_21: Microcontroller access stalls while others hold DRAM; nothing lost.
// RULE_22: Pointer registers read back the current incremented position.
`timescale 1ns/100ps
module shared_display_memory_access #(
    parameter int REFRESH_CYCLES = dram_access_pkg::REFRESH_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Power state
    input wire logic power_down,
    // Data capture client
    input wire logic cap_req,
    input wire logic cap_we,
    input wire logic [13:0] cap_addr,
    input wire logic [7:0] cap_wdata,
    output logic cap_gnt,
    output logic cap_rvalid,
    // Display client
    input wire logic disp_req,
    input wire logic [13:0] disp_addr,
    output logic disp_gnt,
    output logic disp_rvalid,
    // Shared read data for capture and display
    output logic [7:0] rd_data,
    // External data move port
    input wire logic xdm_req,
    input wire logic xdm_we,
    input wire logic [15:0] xdm_addr,
    input wire logic [7:0] xdm_wdata,
    output logic xdm_ack,
    output logic [7:0] xdm_rdata,
    // Register port
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [2:0] sfr_sel,
    input wire logic [7:0] sfr_wdata,
    output logic sfr_ack,
    output logic [7:0] sfr_rdata,
    // Status
    output logic page_clearing,
    // DRAM array
    output logic dram_req,
    output logic dram_we,
    output logic dram_refresh,
    output logic [13:0] dram_addr,
    output logic [7:0] dram_wdata,
    input wire logic [7:0] dram_rdata
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        dram_access_pkg::phase_t phase;
        logic [11:0] ref_cnt;
        logic ref_pend;
        logic [13:0] clr_addr;
        logic [4:0] row;
        logic [5:0] col;
        logic [3:0] blk;
        logic sfr_pend;
        logic sfr_wait;
        logic sfr_we;
        logic [7:0] sfr_wd;
        logic xdm_busy;
        dram_access_pkg::owner_t iss_own;
        dram_access_pkg::owner_t wait_own;
        logic dram_req;
        logic dram_we;
        logic dram_ref;
        logic [13:0] dram_addr;
        logic [7:0] dram_wdata;
        logic cap_gnt;
        logic disp_gnt;
        logic cap_rv;
        logic disp_rv;
        logic [7:0] rd_data;
        logic xdm_ack;
        logic [7:0] xdm_rdata;
        logic sfr_ack;
        logic [7:0] sfr_rdata;
        logic clearing;
    } state_t;

    localparam logic [11:0] REF_LAST = 12'(REFRESH_CYCLES - 1);

    state_t q;
    state_t d;
    logic xdm_hit;
    logic [13:0] xdm_phys;
    logic [13:0] sfr_phys;
    logic xdm_issue;
    logic sfr_issue;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    xdm_map u_map (
        .addr(xdm_addr),
        .hit(xdm_hit),
        .phys(xdm_phys)
    );

    // Block base plus row/column offset
    assign sfr_phys = 14'(dram_access_pkg::DISP_PHYS_BASE
        + {q.blk, dram_access_pkg::rc_offset(q.row, q.col)}); // [RULE_12] [RULE_13] [RULE_18] [RULE_19]

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        xdm_issue = 1'b0;
        sfr_issue = 1'b0;
        d.dram_req = 1'b0;
        d.dram_we = 1'b0;
        d.dram_ref = 1'b0;
        d.cap_gnt = 1'b0;
        d.disp_gnt = 1'b0;
        d.cap_rv = 1'b0;
        d.disp_rv = 1'b0;
        d.xdm_ack = 1'b0;
        d.sfr_ack = 1'b0;
        d.iss_own = dram_access_pkg::OWN_NONE;
        d.wait_own = q.iss_own;
        // Read data return, one cycle after the array access
        unique case (q.wait_own)
            dram_access_pkg::OWN_CAP: begin
                d.cap_rv = 1'b1;
                d.rd_data = dram_rdata;
            end
            dram_access_pkg::OWN_DISP: begin
                d.disp_rv = 1'b1;
                d.rd_data = dram_rdata;
            end
            dram_access_pkg::OWN_XDM: begin
                d.xdm_ack = 1'b1;
                d.xdm_rdata = dram_rdata;
                d.xdm_busy = 1'b0;
            end
            dram_access_pkg::OWN_SFR: begin
                d.sfr_ack = 1'b1;
                d.sfr_rdata = dram_rdata;
                d.sfr_pend = 1'b0;
                d.sfr_wait = 1'b0;
            end
            dram_access_pkg::OWN_NONE: begin
            end
            default: begin
            end
        endcase
        // Register port strobes
        if ((sfr_wr || sfr_rd) && !q.sfr_pend) begin
            d.sfr_ack = 1'b1;
            unique case (sfr_sel)
                dram_access_pkg::SEL_ROW: begin
                    if (sfr_wr) begin
                        d.row = sfr_wdata[4:0];
                    end
                    d.sfr_rdata = 8'(q.row); // [RULE_22]
                end
                dram_access_pkg::SEL_COL: begin
                    if (sfr_wr) begin
                        d.col = sfr_wdata[5:0];
                    end
                    d.sfr_rdata = 8'(q.col); // [RULE_22]
                end
                dram_access_pkg::SEL_BLOCK: begin
                    if (sfr_wr) begin
                        d.blk = sfr_wdata[3:0];
                    end
                    d.sfr_rdata = 8'(q.blk);
                end
                dram_access_pkg::SEL_STATUS: begin
                    d.sfr_rdata = 8'(q.clearing);
                end
                dram_access_pkg::SEL_DATA: begin
                    d.sfr_ack = 1'b0;
                    d.sfr_pend = 1'b1;
                    d.sfr_we = sfr_wr;
                    d.sfr_wd = sfr_wdata;
                end
                default: begin
                    d.sfr_rdata = '0;
                end
            endcase
        end
        // Unmapped external data address answers at once with zero
        if (xdm_req && !xdm_hit && !q.xdm_busy && !q.xdm_ack) begin
            d.xdm_ack = 1'b1;
            d.xdm_rdata = '0;
        end
        // Arbitration: refresh, clear, capture, display, register port, data move
        if (q.ref_pend) begin
            d.dram_ref = 1'b1; // [RULE_01]
            d.ref_pend = 1'b0;
        end else if (q.phase == dram_access_pkg::ST_CLEAR) begin
            d.dram_req = 1'b1; // [RULE_20] [RULE_05] [RULE_06]
            d.dram_we = 1'b1;
            d.dram_addr = q.clr_addr;
            d.dram_wdata = dram_access_pkg::SPACE_CODE;
            if (q.clr_addr == dram_access_pkg::DISP_PHYS_LAST) begin
                d.phase = dram_access_pkg::ST_RUN;
                d.clearing = 1'b0;
            end else begin
                d.clr_addr = 14'(q.clr_addr + 14'h0001);
            end
        end else if (cap_req && !q.cap_gnt) begin
            d.dram_req = 1'b1; // [RULE_02]
            d.dram_we = cap_we;
            d.dram_addr = cap_addr;
            d.dram_wdata = cap_wdata;
            d.cap_gnt = 1'b1;
            d.iss_own = cap_we ? dram_access_pkg::OWN_NONE : dram_access_pkg::OWN_CAP;
        end else if (disp_req && !q.disp_gnt) begin
            d.dram_req = 1'b1; // [RULE_02]
            d.dram_addr = disp_addr;
            d.disp_gnt = 1'b1;
            d.iss_own = dram_access_pkg::OWN_DISP;
        end else if (q.sfr_pend && !q.sfr_wait) begin
            sfr_issue = 1'b1;
            d.dram_req = 1'b1; // [RULE_11] [RULE_10]
            d.dram_we = q.sfr_we;
            d.dram_addr = sfr_phys;
            d.dram_wdata = q.sfr_wd;
            {d.row, d.col} = dram_access_pkg::next_pos(q.row, q.col); // [RULE_14] [RULE_15] [RULE_16]
            if (q.sfr_we) begin
                d.sfr_ack = 1'b1;
                d.sfr_pend = 1'b0;
            end else begin
                d.sfr_wait = 1'b1;
                d.iss_own = dram_access_pkg::OWN_SFR;
            end
        end else if (xdm_req && xdm_hit && !q.xdm_busy && !q.xdm_ack) begin
            xdm_issue = 1'b1;
            d.dram_req = 1'b1; // [RULE_02] [RULE_21]
            d.dram_we = xdm_we;
            d.dram_addr = xdm_phys;
            d.dram_wdata = xdm_wdata;
            if (xdm_we) begin
                d.xdm_ack = 1'b1;
            end else begin
                d.xdm_busy = 1'b1;
                d.iss_own = dram_access_pkg::OWN_XDM;
            end
        end
        // Refresh timer; a new request wins over the issue above
        if (q.ref_cnt == REF_LAST) begin
            d.ref_cnt = '0;
            if (!power_down) begin
                d.ref_pend = 1'b1; // [RULE_01] [RULE_04]
            end
        end else begin
            d.ref_cnt = 12'(q.ref_cnt + 12'h001);
        end
    end

    // ------------------------------------------------------------
    // State register; reset starts a full clear, auxiliary area untouched
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.phase <= dram_access_pkg::ST_CLEAR; // [RULE_06] [RULE_03]
            q.clr_addr <= dram_access_pkg::DISP_PHYS_BASE;
            q.clearing <= 1'b1; // [RULE_20]
            q.iss_own <= dram_access_pkg::OWN_NONE;
            q.wait_own <= dram_access_pkg::OWN_NONE;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign cap_gnt = q.cap_gnt;
    assign cap_rvalid = q.cap_rv;
    assign disp_gnt = q.disp_gnt;
    assign disp_rvalid = q.disp_rv;
    assign rd_data = q.rd_data;
    assign xdm_ack = q.xdm_ack;
    assign xdm_rdata = q.xdm_rdata;
    assign sfr_ack = q.sfr_ack;
    assign sfr_rdata = q.sfr_rdata;
    assign page_clearing = q.clearing;
    assign dram_req = q.dram_req;
    assign dram_we = q.dram_we;
    assign dram_refresh = q.dram_ref;
    assign dram_addr = q.dram_addr;
    assign dram_wdata = q.dram_wdata;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    clear_done_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_20]
        $fell(page_clearing) |-> dram_req && dram_we
            && dram_addr == dram_access_pkg::DISP_PHYS_LAST)
        else $error("clear flag dropped before last location written");
    clear_value_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_05]
        page_clearing && dram_req |-> dram_we && dram_wdata == dram_access_pkg::SPACE_CODE)
        else $error("clear wrote a value other than space");
    one_grant_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_01]
        (cap_gnt || disp_gnt) |-> dram_req && !(cap_gnt && disp_gnt) && !dram_refresh)
        else $error("grant without a single array access");
    refresh_issue_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_01]
        q.ref_pend |=> dram_refresh && !dram_req)
        else $error("pending refresh not issued next cycle");
    col_wrap_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_15]
        sfr_issue && q.col == dram_access_pkg::COL_LAST && q.row < dram_access_pkg::ROW_END
            |=> q.col == '0 && q.row == 5'($past(q.row) + 5'h01))
        else $error("column did not wrap into next row");
    end_wrap_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_16]
        sfr_issue && q.row == dram_access_pkg::ROW_END && q.col == dram_access_pkg::COL_END
            |=> q.col == '0 && q.row == '0)
        else $error("pointer did not return to origin");
    ttx_map_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_08]
        xdm_issue && xdm_addr >= dram_access_pkg::TTX_LO && xdm_addr <= dram_access_pkg::TTX_HI
            |=> dram_addr == 14'(dram_access_pkg::DISP_PHYS_BASE
                + 14'($past(xdm_addr) - dram_access_pkg::TTX_LO)))
        else $error("teletext address mapped wrongly");
    port_range_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_10]
        sfr_issue |=> dram_req && dram_addr >= dram_access_pkg::DISP_PHYS_BASE)
        else $error("register port reached auxiliary area");
    xdm_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_21]
        xdm_issue && !xdm_we |=> !xdm_ack ##1 !xdm_ack ##1 xdm_ack)
        else $error("external data move read not answered in time");
endmodule

// *** shared_display_memory_access_tb.sv ***
// Self-checking bench for the shared display memory access block
`timescale 1ns/100ps
module shared_display_memory_access_tb;
    logic clk, rst_n, cap_req, cap_we, disp_req, xdm_req, xdm_we, sfr_wr, sfr_rd, power_down;
    logic cap_gnt, cap_rvalid, disp_gnt, disp_rvalid, xdm_ack, sfr_ack, page_clearing;
    logic dram_req, dram_we, dram_refresh;
    logic [13:0] cap_addr, disp_addr, dram_addr;
    logic [15:0] xdm_addr;
    logic [7:0] cap_wdata, rd_data, xdm_wdata, xdm_rdata, sfr_wdata, sfr_rdata;
    logic [7:0] dram_wdata, dram_rdata, rv, d;
    logic [2:0] sfr_sel;
    int err_total, cmp_count, b, r, c, nr, nc, ks[$];
    logic [7:0] shadow [int];
    shared_display_memory_access #(.REFRESH_CYCLES(16)) i_shared_display_memory_access (
        .clk(clk), .rst_n(rst_n), .power_down(power_down),
        .cap_req(cap_req), .cap_we(cap_we), .cap_addr(cap_addr), .cap_wdata(cap_wdata),
        .cap_gnt(cap_gnt), .cap_rvalid(cap_rvalid), .disp_req(disp_req),
        .disp_addr(disp_addr), .disp_gnt(disp_gnt), .disp_rvalid(disp_rvalid),
        .rd_data(rd_data), .xdm_req(xdm_req), .xdm_we(xdm_we), .xdm_addr(xdm_addr),
        .xdm_wdata(xdm_wdata), .xdm_ack(xdm_ack), .xdm_rdata(xdm_rdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_sel(sfr_sel), .sfr_wdata(sfr_wdata),
        .sfr_ack(sfr_ack), .sfr_rdata(sfr_rdata), .page_clearing(page_clearing),
        .dram_req(dram_req), .dram_we(dram_we), .dram_refresh(dram_refresh),
        .dram_addr(dram_addr), .dram_wdata(dram_wdata), .dram_rdata(dram_rdata)
    );
    dram_array_model i_dram_array_model (
        .clk(clk), .dram_req(dram_req), .dram_we(dram_we), .dram_refresh(dram_refresh),
        .dram_addr(dram_addr), .dram_wdata(dram_wdata), .dram_rdata(dram_rdata)
    );
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Reference model and checking
    // ------------------------------------------------------------
    function automatic int ph(int a);
        if (a < 'h800) return a;
        if (a >= 'h2000 && a <= 'h47ff) return a - 'h1800;
        if (a >= 'h8000 && a <= 'h84ff) return a - 'h7800;
        return -1;
    endfunction
    function automatic logic [7:0] ev(int p);
        if (p < 0) return 8'h00;
        if (shadow.exists(p)) return shadow[p];
        return 8'h20;
    endfunction
    function automatic int xa(int bk, int rw, int cl);
        return 'h2000 + bk * 'h400 + (cl < 32 ? rw * 32 + cl : 'h3f8 - 8 * rw + cl - 32);
    endfunction
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic limit(input int n, input int m = 30000);
        if (n >= m) begin
            err_total++;
            $display("[FAIL] handshake expected 1 seen 0");
            wrap_up();
        end
    endtask
    // ------------------------------------------------------------
    // Port drivers
    // ------------------------------------------------------------
    task automatic xdm(input logic we, input int a, input logic [7:0] wd);
        int n;
        xdm_req = 1'b1;
        xdm_we = we;
        xdm_addr = 16'(a);
        xdm_wdata = wd;
        n = 0;
        do begin @(posedge clk); #1; n++; end while (xdm_ack !== 1'b1 && n < 30000);
        rv = xdm_rdata;
        xdm_req = 1'b0;
        limit(n);
        if (we && ph(a) >= 0) shadow[ph(a)] = wd;
        @(posedge clk);
        #1;
    endtask
    task automatic xrd(input int a);
        xdm(1'b0, a, 8'h00);
        chk("xdm read", rv, ev(ph(a)));
    endtask
    task automatic sfr(input logic wr, input logic [2:0] sel, input logic [7:0] wd);
        int n;
        sfr_wr = wr;
        sfr_rd = !wr;
        sfr_sel = sel;
        sfr_wdata = wd;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            sfr_wr = 1'b0;
            sfr_rd = 1'b0;
            n++;
        end while (sfr_ack !== 1'b1 && n < 30000);
        rv = sfr_rdata;
        limit(n);
        @(posedge clk);
        #1;
    endtask
    task automatic client(input bit dsp, input logic we, input int a, input logic [7:0] wd);
        int n;
        if (dsp) begin disp_req = 1'b1; disp_addr = 14'(a); end
        else begin cap_req = 1'b1; cap_we = we; cap_addr = 14'(a); cap_wdata = wd; end
        n = 0;
        do begin @(posedge clk); #1; n++; end while ((dsp ? disp_gnt : cap_gnt) !== 1'b1 && n < 30000);
        disp_req = 1'b0;
        cap_req = 1'b0;
        limit(n);
        if (we) shadow[a] = wd;
        n = 0;
        while (!we && (dsp ? disp_rvalid : cap_rvalid) !== 1'b1 && n < 9) begin
            @(posedge clk); #1; n++;
        end
        if (!we) limit(n, 9);
        rv = rd_data;
        @(posedge clk);
        #1;
    endtask
    task automatic reset_and_clear();
        int n;
        rst_n = 1'b0;
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        sfr(1'b0, dram_access_pkg::SEL_STATUS, 8'h00);
        chk("clear flag", rv, 8'h01);
        n = 0;
        do begin @(posedge clk); #1; n++; end while (page_clearing !== 1'b0 && n < 30000);
        limit(n);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h1ea3bfd1));
        {cap_req, cap_we, disp_req, xdm_req, xdm_we, sfr_wr, sfr_rd, power_down} = 8'h00;
        {cap_addr, disp_addr, xdm_addr, cap_wdata, xdm_wdata, sfr_wdata, sfr_sel} = '0;
        err_total = 0;
        cmp_count = 0;
        reset_and_clear();
        xrd('h2000);
        xrd('h47ff);
        xdm(1'b1, 'h0000, 8'ha5);
        xdm(1'b1, 'h07ff, 8'h3c);
        xrd('h0000);
        xrd('h07ff);
        xrd('h0800);
        xdm(1'b1, 'h8000, 8'h77);
        xrd('h2000);
        xdm(1'b1, 'h84ff, 8'h19);
        xrd('h24ff);
        sfr(1'b1, dram_access_pkg::SEL_BLOCK, 8'h02);
        for (int i = 0; i < 12; i++) begin
            b = (i < 2) ? 2 : $urandom % 10;
            r = (i == 0) ? 0 : (i == 1) ? 25 : $urandom % 25;
            c = (i == 0) ? 39 : (i == 1) ? 23 : $urandom % 40;
            d = 8'($urandom);
            nr = (r == 25 && c == 23) ? 0 : (c == 39) ? r + 1 : r;
            nc = (c == 39 || (r == 25 && c == 23)) ? 0 : c + 1;
            sfr(1'b1, dram_access_pkg::SEL_BLOCK, 8'(b));
            sfr(1'b1, dram_access_pkg::SEL_ROW, 8'(r));
            sfr(1'b1, dram_access_pkg::SEL_COL, 8'(c));
            sfr(1'b1, dram_access_pkg::SEL_DATA, d);
            shadow[ph(xa(b, r, c))] = d;
            sfr(1'b0, dram_access_pkg::SEL_ROW, 8'h00);
            chk("row pointer", rv, 8'(nr));
            sfr(1'b0, dram_access_pkg::SEL_COL, 8'h00);
            chk("column pointer", rv, 8'(nc));
            xrd(xa(b, r, c));
            sfr(1'b1, dram_access_pkg::SEL_ROW, 8'(r));
            sfr(1'b1, dram_access_pkg::SEL_COL, 8'(c));
            sfr(1'b0, dram_access_pkg::SEL_DATA, 8'h00);
            chk("port data", rv, d);
            sfr(1'b0, dram_access_pkg::SEL_COL, 8'h00);
            chk("column after read", rv, 8'(nc));
        end
        fork
            client(1'b0, 1'b1, 'h0a00, 8'h66);
            xdm(1'b1, 'h2300, 8'h99);
        join
        client(1'b1, 1'b0, 'h0b00, 8'h00);
        chk("display read", rv, 8'h99);
        client(1'b0, 1'b0, 'h0a00, 8'h00);
        chk("capture read", rv, 8'h66);
        power_down = 1'b1;
        repeat (2) @(posedge clk);
        for (int p = 0; p < 2; p++) begin
            c = 0;
            repeat (32) begin @(posedge clk); #1; c += dram_refresh; end
            chk("refresh pulses", 8'(c), 8'(2 * p));
            power_down = 1'b0;
        end
        foreach (shadow[k]) if (k >= 'h800) ks.push_back(k);
        foreach (ks[i]) shadow.delete(ks[i]);
        reset_and_clear();
        xrd('h0000);
        xrd('h2300);
        xrd('h2000);
        wrap_up();
    end
endmodule
